// [rtl/cscp_control_port.sv]
// Notes on behaviour
// - Mode pin low two-wire, high three-wire
// - Word is 7 address then 9 data
// - Three-wire samples one bit per clock rise
// - Latch rise takes last sixteen bits
// - Slave only; start is data fall, clock high
// - Shift seven address bits and the read/write bit, MSB first
// - Matching address is acknowledged by pulling low
// - Mismatch or read bit: no ack, idle
// - First data byte holds B15..B8, acknowledged
// - Second byte holds B7..B0, acknowledged
// - Stop returns to idle
// - Unexpected change while clock high aborts
// - Fixed bus address 0011010
// - Write to address zero resets all registers
// - Reset loads defaults before any word
// - Latch pin acts only when function select is three-wire
module cscp_control_port #(
  parameter int REGS = cscp_pkg::REG_COUNT
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic modePin,
  input wire logic serialClockPin,
  input wire logic serialDataPinIn,
  output logic serialDataPinOut,
  output logic serialDataPinOe,
  input wire logic chipSelectLatchPin,
  input wire logic [6:0] readAddr,
  output logic [8:0] readData,
  output logic wordStrobe,
  output logic [15:0] lastWord
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic modeS;
  logic sclkS;
  logic sdaS;
  logic csS;

  cscp_sync uSyncMode (.clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(modePin), .pinSync(modeS));
  cscp_sync uSyncClk (.clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(serialClockPin),
    .pinSync(sclkS));
  cscp_sync uSyncDat (.clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(serialDataPinIn),
    .pinSync(sdaS));
  cscp_sync uSyncCs (.clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(chipSelectLatchPin),
    .pinSync(csS));

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised pins
  logic sclkD_r;
  logic sdaD_r;
  logic csD_r;
  logic sclkRise;
  logic sclkFall;
  logic csRise;
  logic startCond;
  logic stopCond;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclkD_r <= 1'b1;
      sdaD_r <= 1'b1;
      csD_r <= 1'b1;
    end else begin
      sclkD_r <= sclkS;
      sdaD_r <= sdaS;
      csD_r <= csS;
    end
  end

  always_comb begin
    sclkRise = sclkS & ~sclkD_r;
    sclkFall = ~sclkS & sclkD_r;
    csRise = csS & ~csD_r; // Latch edge; it commits a word only when function select is three-wire
    startCond = sclkS & sclkD_r & sdaD_r & ~sdaS;
    stopCond = sclkS & sclkD_r & ~sdaD_r & sdaS;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Three-wire shifter: keeps last sixteen bits, MSB enters first
  logic [15:0] shift3_r;
  logic [15:0] shift3_nxt;

  always_comb begin
    shift3_nxt = shift3_r;
    if (modeS && sclkRise) begin
      shift3_nxt = {shift3_r[14:0], sdaS};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shift3_r <= 16'h0000;
    end else begin
      shift3_r <= shift3_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire receiver
  cscp_pkg::cscp_tw_state_e state_r;
  cscp_pkg::cscp_tw_state_e state_nxt;
  logic [3:0] bitCnt_r;
  logic [3:0] bitCnt_nxt;
  logic [7:0] byte_r;
  logic [7:0] byte_nxt;
  logic [15:0] word2_r;
  logic [15:0] word2_nxt;
  logic byteIdx_r;
  logic byteIdx_nxt;
  logic ackDrive_r;
  logic ackDrive_nxt;
  logic word2Done;

  always_comb begin
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    byte_nxt = byte_r;
    word2_nxt = word2_r;
    byteIdx_nxt = byteIdx_r;
    ackDrive_nxt = ackDrive_r;
    word2Done = 1'b0;
    if (modeS) begin
      state_nxt = cscp_pkg::IDLE;
      ackDrive_nxt = 1'b0;
    end else if (startCond) begin
      // A start anywhere restarts address reception
      state_nxt = cscp_pkg::ADDR_BYTE;
      bitCnt_nxt = 4'h0;
      ackDrive_nxt = 1'b0;
    end else if (stopCond) begin
      state_nxt = cscp_pkg::IDLE;
      ackDrive_nxt = 1'b0;
    end else begin
      case (state_r)
        cscp_pkg::ADDR_BYTE, cscp_pkg::DATA_BYTE: begin
          if (sclkRise) begin
            byte_nxt = {byte_r[6:0], sdaS};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          if (sclkFall && bitCnt_r == cscp_pkg::BITS_PER_BYTE) begin
            bitCnt_nxt = 4'h0;
            if (state_r == cscp_pkg::ADDR_BYTE) begin
              // Ack only own address with write bit
              if (byte_r[7:1] == cscp_pkg::OWN_BUS_ADDR && !byte_r[0]) begin
                state_nxt = cscp_pkg::ADDR_ACK;
                ackDrive_nxt = 1'b1;
                byteIdx_nxt = 1'b0;
              end else begin
                state_nxt = cscp_pkg::IDLE;
              end
            end else begin
              state_nxt = cscp_pkg::DATA_ACK;
              ackDrive_nxt = 1'b1;
              if (!byteIdx_r) begin
                word2_nxt[15:8] = byte_r;
              end else begin
                word2_nxt[7:0] = byte_r;
              end
            end
          end
        end
        cscp_pkg::ADDR_ACK: begin
          // Release after the ack clock pulse ends
          if (sclkFall) begin
            ackDrive_nxt = 1'b0;
            state_nxt = cscp_pkg::DATA_BYTE;
          end
        end
        cscp_pkg::DATA_ACK: begin
          if (sclkFall) begin
            ackDrive_nxt = 1'b0;
            if (!byteIdx_r) begin
              byteIdx_nxt = 1'b1;
              state_nxt = cscp_pkg::DATA_BYTE;
            end else begin
              word2Done = 1'b1;
              state_nxt = cscp_pkg::WAIT_STOP;
            end
          end
        end
        cscp_pkg::WAIT_STOP: begin
          state_nxt = cscp_pkg::WAIT_STOP;
        end
        default: begin
          state_nxt = cscp_pkg::IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= cscp_pkg::IDLE;
      bitCnt_r <= 4'h0;
      byte_r <= 8'h00;
      word2_r <= 16'h0000;
      byteIdx_r <= 1'b0;
      ackDrive_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      byte_r <= byte_nxt;
      word2_r <= word2_nxt;
      byteIdx_r <= byteIdx_nxt;
      ackDrive_r <= ackDrive_nxt;
    end
  end

  // Open-drain data pin: drives low only during acknowledge
  assign serialDataPinOut = 1'b0;
  assign serialDataPinOe = ackDrive_r;

  ////////////////////////////////////////////////////////////////////////////
  // Word commit and register file
  logic commit;
  logic [15:0] commitWord;
  logic [8:0] regs_r [REGS];
  logic [8:0] regs_nxt [REGS];
  logic wordStrobe_nxt;
  logic [15:0] lastWord_r;
  logic [15:0] lastWord_nxt;
  logic [6:0] wAddr;

  always_comb begin
    commit = (modeS && csRise) || word2Done;
    commitWord = modeS ? shift3_r : word2_nxt;
    wAddr = commitWord[cscp_pkg::ADDR_MSB:cscp_pkg::ADDR_LSB];
    wordStrobe_nxt = commit;
    lastWord_nxt = commit ? commitWord : lastWord_r;
  end

  // One write path per register; the reset word clears them all
  for (genvar i = 0; i < REGS; i++) begin : gRegs
    always_comb begin
      regs_nxt[i] = regs_r[i];
      if (commit && wAddr == cscp_pkg::SOFTWARE_RESET_TRIGGER_OFS) begin
        regs_nxt[i] = cscp_pkg::REG_RESET_VAL;
      end else if (commit && wAddr == 7'(i)) begin
        regs_nxt[i] = commitWord[cscp_pkg::DATA_MSB:0];
      end
    end

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        regs_r[i] <= cscp_pkg::REG_RESET_VAL;
      end else begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wordStrobe <= 1'b0;
      lastWord_r <= 16'h0000;
      readData <= 9'h000;
    end else begin
      wordStrobe <= wordStrobe_nxt;
      lastWord_r <= lastWord_nxt;
      // Trigger register is write-only and reads zero
      readData <= regs_r[readAddr];
    end
  end

  assign lastWord = lastWord_r;
endmodule : cscp_control_port

// [rtl/cscp_pkg.sv]
package cscp_pkg;
  // Control word layout
  localparam int WORD_W = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 9;
  localparam int DATA_MSB = 8;
  // Register file
  localparam int REG_COUNT = 128;
  localparam logic [6:0] SOFTWARE_RESET_TRIGGER_OFS = 7'h00;
  localparam logic [8:0] REG_RESET_VAL = 9'h000;
  // Two-wire bus address
  localparam logic [6:0] OWN_BUS_ADDR = 7'h1a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Two-wire receive states
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    ADDR_BYTE = 3'b001,
    ADDR_ACK = 3'b010,
    DATA_BYTE = 3'b011,
    DATA_ACK = 3'b100,
    WAIT_STOP = 3'b101
  } cscp_tw_state_e;
endpackage : cscp_pkg

// [rtl/cscp_sync.sv]
// Two-flop synchroniser for one pin; first stage read only by the second
module cscp_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pinIn,
  output logic pinSync
);
  logic stage1_r;
  logic stage2_r;
  logic stage1_nxt;
  logic stage2_nxt;

  // Next values
  always_comb begin
    stage1_nxt = pinIn;
    stage2_nxt = stage1_r;
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage1_r <= 1'b1;
      stage2_r <= 1'b1;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign pinSync = stage2_r;
endmodule : cscp_sync

// [tb/cscp_host.sv]
module cscp_host (
  input wire logic clk_sys,
  input wire logic sdaBus,
  output logic serialClockPin,
  output logic hostSda,
  output logic chipSelectLatchPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus: clock and data high, latch low
  initial begin
    serialClockPin = 1'b1;
    hostSda = 1'b1;
    chipSelectLatchPin = 1'b0;
  end
  ////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  // Data moves mid-low so it never changes while the clock is high
  task automatic bit1(input logic b);
    serialClockPin <= 1'b0;
    wt(2);
    hostSda <= b;
    wt(2);
    serialClockPin <= 1'b1;
    wt(4);
  endtask : bit1
  // Start is cond(1,0), stop is cond(0,1): data moves while clock is high
  task automatic cond(input logic b0, input logic b1);
    bit1(b0);
    hostSda <= b1;
    wt(4);
  endtask : cond
  // Eight bits first to last, then a released ninth bit that carries the ack
  task automatic byte8(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bit1(v[i]);
    bit1(1'b1);
    ack = !sdaBus;
  endtask : byte8
  task automatic send3(input logic [19:0] v);
    for (int i = 19; i >= 0; i--) bit1(v[i]);
    chipSelectLatchPin <= 1'b1;
    wt(4);
    chipSelectLatchPin <= 1'b0;
    hostSda <= ~hostSda; // Hold time over: data no longer valid
    wt(4);
  endtask : send3
  task automatic send2(input logic [7:0] hdr, input logic [15:0] w, output logic [2:0] acks);
    cond(1'b1, 1'b0);
    byte8(hdr, acks[2]);
    byte8(w[15:8], acks[1]);
    byte8(w[7:0], acks[0]);
    cond(1'b0, 1'b1);
  endtask : send2
endmodule : cscp_host

// [tb/cscp_monitor.sv]
module cscp_monitor #(
  parameter int REGS = cscp_pkg::REG_COUNT
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic modePin,
  input wire logic serialClockPin,
  input wire logic serialDataPinIn,
  input wire logic serialDataPinOut,
  input wire logic serialDataPinOe,
  input wire logic chipSelectLatchPin,
  input wire logic [6:0] readAddr,
  input wire logic [8:0] readData,
  input wire logic wordStrobe,
  input wire logic [15:0] lastWord
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Ack covers a full clock high phase; strobes of two words lie far apart
  sequence ackHold; serialDataPinOe [*6]; endsequence
  sequence quiet; !wordStrobe [*8]; endsequence
  ////////////////////////////////////////
  rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> !wordStrobe &&
    !serialDataPinOe && lastWord == 16'h0000 && readData == 9'h000) else $error("no reset");
  strobe_once_a: assert property (wordStrobe |=> quiet) else $error("strobe too long");
  word_hold_a: assert property ($changed(lastWord) |-> wordStrobe) else $error("word moved");
  ack_span_a: assert property ($rose(serialDataPinOe) |-> ackHold) else $error("ack short");
  ack_mode_a: assert property (serialDataPinOe |-> !modePin) else $error("ack in 3-wire");
  latch_word_a: assert property (modePin && $rose(chipSelectLatchPin) |-> ##[2:7] wordStrobe)
    else $error("latch lost");
  soft_clear_a: assert property (wordStrobe && lastWord[15:9] == 7'h00 |=>
    readData == 9'h000) else $error("not cleared");
  write_read_a: assert property (wordStrobe && lastWord[15:9] != 7'h00 &&
    readAddr == lastWord[15:9] |=> readData == lastWord[8:0]) else $error("bad write");
endmodule : cscp_monitor

bind cscp_control_port cscp_monitor #(.REGS(REGS)) u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .modePin(modePin), .serialClockPin(serialClockPin), .serialDataPinIn(serialDataPinIn),
  .serialDataPinOut(serialDataPinOut), .serialDataPinOe(serialDataPinOe),
  .chipSelectLatchPin(chipSelectLatchPin), .readAddr(readAddr), .readData(readData),
  .wordStrobe(wordStrobe), .lastWord(lastWord));

// [tb/tb_codec_serial_control_port.sv]
module tb_codec_serial_control_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst, modePin, scl, hostSda, csl, dataOut, dataOe, wordStrobe, m, f, rw, ok;
  logic [6:0] readAddr, a;
  logic [8:0] readData;
  logic [15:0] lastWord, w;
  logic [2:0] acks;
  logic [8:0] mem [128] = '{default: 9'h000};
  int seed = 32'hdf51;
  int nErrors, testsRun, nStr, n0;
  wire logic sdaBus;
  // Open-drain wire: pulled up, low when either side pulls
  assign sdaBus = hostSda & ~(dataOe & ~dataOut);
  always #25 clk_sys = ~clk_sys;
  // Count accepted words
  always @(posedge clk_sys) if (wordStrobe === 1'b1) nStr <= nStr + 1;
  cscp_host host (.clk_sys(clk_sys), .sdaBus(sdaBus), .serialClockPin(scl), .hostSda(hostSda),
    .chipSelectLatchPin(csl));
  cscp_control_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .modePin(modePin),
    .serialClockPin(scl), .serialDataPinIn(sdaBus), .serialDataPinOut(dataOut),
    .serialDataPinOe(dataOe), .chipSelectLatchPin(csl), .readAddr(readAddr),
    .readData(readData), .wordStrobe(wordStrobe), .lastWord(lastWord));
  ////////////////////////////////////////
  function automatic logic [2:0] ackExp(input logic [6:0] ad, input logic r, input logic md);
    return (!md && ad == 7'h1a && !r) ? 3'b111 : 3'b000;
  endfunction : ackExp
  function automatic void commit(input logic [15:0] v);
    if (v[15:9] == 7'h00) begin
      for (int k = 0; k < 128; k++) mem[k] = 9'h000;
    end else mem[v[15:9]] = v[8:0];
  endfunction : commit
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkAll();
    for (int k = 0; k < 128; k++) begin
      readAddr <= 7'(k);
      repeat (2) @(posedge clk_sys);
      chk({7'h00, readData}, {7'h00, mem[k]});
    end
  endtask : chkAll
  task automatic tallyAndFinish();
    $display("checks %0d, mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tallyAndFinish
  // Whole run is well under 0.5 ms; this cuts a hung handshake short
  initial begin
    #2000000;
    nErrors++;
    tallyAndFinish();
  end
  // Random words in both formats, with wrong format, foreign address, read bit, soft reset
  initial begin
    sys_rst = 1'b1;
    modePin = 1'b0;
    readAddr = 7'h00;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chkAll();
    for (int i = 0; i < 13; i++) begin
      w = 16'($random(seed));
      if (i == 4) w[15:9] = 7'h00;
      m = i[0];
      f = (i == 8 || i == 9) ? ~m : m;
      a = (i == 6) ? 7'h1b : 7'h1a;
      rw = (i == 10);
      if (i == 12) w[9] = 1'b1;
      modePin <= m;
      readAddr <= w[15:9];
      repeat (8) @(posedge clk_sys);
      if (i == 12) begin
        // Two-wire mode must already be in force, or the cut word is never seen
        host.cond(1'b1, 1'b0);
        host.byte8({7'h1a, 1'b0}, acks[2]);
        host.byte8(8'hff, acks[1]);
        chk({14'h0000, acks[2:1]}, 16'h0003);
      end
      n0 = nStr;
      if (f) host.send3({4'($random(seed)), w});
      else begin
        host.send2({a, rw}, w, acks);
        chk({13'h0000, acks}, {13'h0000, ackExp(a, rw, m)});
      end
      ok = (f == m) && (m || ackExp(a, rw, m) == 3'b111);
      repeat (8) @(posedge clk_sys);
      chk(16'(nStr - n0), {15'h0000, ok});
      if (ok) begin
        chk(lastWord, w);
        commit(w);
      end
      chkAll();
    end
    tallyAndFinish();
  end
endmodule : tb_codec_serial_control_port
